/* rtl/dbs_cfg.svh */
/*
  Constants of the burst SRAM data port: widths, burst shape, buffer depth
  and reset values of the handshake toggles.
  Assumes it is included by bare name from the package and the modules.
*/
`ifndef DBS_CFG_SVH
`define DBS_CFG_SVH

// Data and address shape
`define DBS_DATA_W 36
`define DBS_ADDR_W 22
`define DBS_BYTE_N 4
`define DBS_BYTE_W 9

// Burst and buffering
`define DBS_BURST_LEN 2
`define DBS_FIFO_DEPTH 2

// Reset values
`define DBS_TGL_RST 1'b0
`define DBS_OE_N_RST 1'b1

`endif

/* rtl/dbs_pkg.sv */
/*
  Types of the burst SRAM data port: command, burst record, read pair and
  the core-side sequencer states.
  Assumes dbs_cfg.svh is on the include path.
*/
`include "dbs_cfg.svh"

package dbs_pkg;

  // Cycle definition taken at the load edge
  typedef struct packed {
    logic valid;
    logic rd;
    logic [`DBS_ADDR_W-1:0] addr;
  } dbs_cmd_t;

  // Whole burst as it crosses from the link to the core side
  typedef struct packed {
    logic rd;
    logic [`DBS_ADDR_W-1:0] addr;
    logic [`DBS_DATA_W-1:0] d0;
    logic [`DBS_DATA_W-1:0] d1;
    logic [`DBS_BYTE_N-1:0] bws0_n;
    logic [`DBS_BYTE_N-1:0] bws1_n;
  } dbs_burst_t;

  // Read data pair on its way to the read-out clock
  typedef struct packed {
    logic [`DBS_DATA_W-1:0] d0;
    logic [`DBS_DATA_W-1:0] d1;
  } dbs_rdpair_t;

  // Core-side sequencer
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_WR0,
    ST_WR1,
    ST_RD0,
    ST_RW0,
    ST_RD1,
    ST_RW1,
    ST_RET
  } dbs_state_t;

endpackage : dbs_pkg

/* rtl/dbs_fifo.sv */
/*
  Small valid/ready buffer with parameterised width and depth.
  Assumes one clock, synchronous active-high reset, depth a power of two.
*/
`timescale 1ns/100ps

module dbs_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 2
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] FULL_C = (AW + 1)'(DEPTH);

  logic [W-1:0] mem_r [DEPTH];
  logic [AW-1:0] wr_idx_r;
  logic [AW-1:0] rd_idx_r;
  logic [AW:0] count_r;
  wire push = in_valid_i && in_ready_o;
  wire pop = out_valid_o && out_ready_i;

  // Honest full and empty from the fill count
  assign in_ready_o = (count_r != FULL_C);
  assign out_valid_o = (count_r != '0);
  assign out_data_o = mem_r[rd_idx_r];

  // Storage
  always_ff @(posedge clock_i) begin
    if (push) begin
      mem_r[wr_idx_r] <= in_data_i;
    end
  end

  // Pointers and count
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      wr_idx_r <= '0;
      rd_idx_r <= '0;
      count_r <= '0;
    end else begin
      if (push) wr_idx_r <= wr_idx_r + 1'b1;
      if (pop) rd_idx_r <= rd_idx_r + 1'b1;
      if (push && !pop) count_r <= count_r + 1'b1;
      else if (pop && !push) count_r <= count_r - 1'b1;
    end
  end

endmodule : dbs_fifo

/* rtl/dbs_port.sv */
/*
  Data and cycle-load port of a double-data-rate two-word burst SRAM.
  Link logic runs on the input clock pair, the core side on clock_i, and
  read data leaves on the output clock pair or, in single clock mode, on
  the input pair. Assumes the core array sits behind the core_* port.
*/
`timescale 1ns/100ps
`include "dbs_cfg.svh"

module dbs_port (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic link_clk_i,
  input wire logic out_clk_i,
  input wire logic single_clock_i,
  input wire logic load_n_i,
  input wire logic read_write_n_i,
  input wire logic [`DBS_ADDR_W-2:0] addr_i,
  input wire logic burst_lsb_i,
  input wire logic [`DBS_DATA_W-1:0] dq_i,
  input wire logic [`DBS_BYTE_N-1:0] byte_write_select_n_i,
  output logic [`DBS_DATA_W-1:0] dq_o,
  output logic dq_oe_n_o,
  output logic overrun_o,
  output logic core_req_o,
  output logic core_we_o,
  output logic [`DBS_ADDR_W-1:0] core_addr_o,
  output logic [`DBS_DATA_W-1:0] core_wdata_o,
  output logic [`DBS_BYTE_N-1:0] core_ben_o,
  input wire logic core_ready_i,
  input wire logic [`DBS_DATA_W-1:0] core_rdata_i,
  input wire logic core_rvalid_i
);

  // ---------------- Link domain (input clock pair) ----------------
  logic lk_rst_m_r;
  logic lk_rst_r;
  dbs_pkg::dbs_cmd_t lk_c0_r;
  dbs_pkg::dbs_cmd_t lk_c1_r;
  logic [`DBS_DATA_W-1:0] lk_d0_r;
  logic [`DBS_DATA_W-1:0] lk_d1_r;
  logic [`DBS_BYTE_N-1:0] lk_b0_r;
  logic [`DBS_BYTE_N-1:0] lk_b1_r;
  dbs_pkg::dbs_burst_t lk_hold_r;
  logic lk_req_tgl_r;
  logic lk_ack_m_r;
  logic lk_ack_r;
  logic lk_overrun_r;

  // ---------------- Core domain (clock_i) ----------------
  logic sy_req_m_r;
  logic sy_req_r;
  logic sy_req_d_r;
  logic sy_pend_r;
  logic sy_ack_tgl_r;
  logic fifo_in_ready;
  logic fifo_out_valid;
  dbs_pkg::dbs_burst_t fifo_out;
  dbs_pkg::dbs_burst_t cur_r;
  dbs_pkg::dbs_state_t state_r;
  logic core_req_r;
  logic core_we_r;
  logic [`DBS_ADDR_W-1:0] core_addr_r;
  logic [`DBS_DATA_W-1:0] core_wdata_r;
  logic [`DBS_BYTE_N-1:0] core_ben_r;
  dbs_pkg::dbs_rdpair_t ret_r;
  logic ret_tgl_r;
  logic ret_ack_m_r;
  logic ret_ack_r;

  // ---------------- Read-out domain ----------------
  logic rc_rst_m_r;
  logic rc_rst_r;
  logic rc_req_m_r;
  logic rc_req_r;
  logic rc_req_d_r;
  logic rc_ack_tgl_r;
  dbs_pkg::dbs_rdpair_t rc_pair_r;
  logic rc_arm_r;
  logic rc_drive_r;
  logic [`DBS_DATA_W-1:0] rc_pos_d_r;
  logic rc_pos_oe_n_r;
  logic [`DBS_DATA_W-1:0] rc_neg_d_r;
  logic rc_neg_oe_n_r;

  // Cycle decode at the primary rising edge
  wire lk_load = !load_n_i;
  wire lk_is_read = read_write_n_i;
  wire lk_busy = (lk_req_tgl_r != lk_ack_r);
  wire lk_launch = lk_c1_r.valid && !lk_busy;

  // Burst assembled from stage two, word one and word two
  dbs_pkg::dbs_burst_t lk_burst;
  assign lk_burst.rd = lk_c1_r.rd;
  assign lk_burst.addr = lk_c1_r.addr;
  assign lk_burst.d0 = lk_d0_r;
  assign lk_burst.d1 = lk_d1_r;
  assign lk_burst.bws0_n = lk_c1_r.rd ? {`DBS_BYTE_N{1'b1}} : lk_b0_r;
  assign lk_burst.bws1_n = lk_c1_r.rd ? {`DBS_BYTE_N{1'b1}} : lk_b1_r;

  // Core reset brought onto the link clock
  always_ff @(posedge link_clk_i) begin
    lk_rst_m_r <= rst_i;
    lk_rst_r <= lk_rst_m_r;
  end

  // Load edge and the edge after it, primary rising edges only
  always_ff @(posedge link_clk_i) begin
    if (lk_rst_r) begin
      lk_c0_r <= '0;
      lk_c1_r <= '0;
    end else begin
      lk_c0_r.valid <= lk_load;
      lk_c0_r.rd <= lk_is_read;
      lk_c0_r.addr <= {addr_i, burst_lsb_i};
      lk_c1_r <= lk_c0_r;
    end
  end

  // Word one and its byte selects on the rising edge after the load
  always_ff @(posedge link_clk_i) begin
    lk_d0_r <= dq_i;
    lk_b0_r <= byte_write_select_n_i;
  end

  // Word two on the complementary rising edge, which is the falling edge here
  always_ff @(negedge link_clk_i) begin
    lk_d1_r <= dq_i;
    lk_b1_r <= byte_write_select_n_i;
  end

  // Launch a whole burst across; held stable until acknowledged
  always_ff @(posedge link_clk_i) begin
    if (lk_rst_r) begin
      lk_req_tgl_r <= `DBS_TGL_RST;
      lk_ack_m_r <= `DBS_TGL_RST;
      lk_ack_r <= `DBS_TGL_RST;
      lk_overrun_r <= 1'b0;
      lk_hold_r <= '0;
    end else begin
      lk_ack_m_r <= sy_ack_tgl_r;
      lk_ack_r <= lk_ack_m_r;
      if (lk_launch) begin
        lk_hold_r <= lk_burst;
        lk_req_tgl_r <= ~lk_req_tgl_r;
      end
      if (lk_c1_r.valid && lk_busy) lk_overrun_r <= 1'b1; // Burst dropped
    end
  end

  // Overrun report, resynchronised to clock_i
  logic ov_m_r;
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      ov_m_r <= 1'b0;
      overrun_o <= 1'b0;
    end else begin
      ov_m_r <= lk_overrun_r;
      overrun_o <= ov_m_r;
    end
  end

  // Request toggle arrival on clock_i
  wire sy_new = sy_req_r ^ sy_req_d_r;
  wire fifo_push_ok = sy_pend_r && fifo_in_ready;
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      sy_req_m_r <= `DBS_TGL_RST;
      sy_req_r <= `DBS_TGL_RST;
      sy_req_d_r <= `DBS_TGL_RST;
      sy_pend_r <= 1'b0;
      sy_ack_tgl_r <= `DBS_TGL_RST;
    end else begin
      sy_req_m_r <= lk_req_tgl_r;
      sy_req_r <= sy_req_m_r;
      sy_req_d_r <= sy_req_r;
      if (sy_new) sy_pend_r <= 1'b1;
      else if (fifo_push_ok) sy_pend_r <= 1'b0;
      if (fifo_push_ok) sy_ack_tgl_r <= ~sy_ack_tgl_r; // Ack withheld while full
    end
  end

  // Two-entry buffer; a burst waits until the last read pair is taken across
  wire fifo_pop = (state_r == dbs_pkg::ST_IDLE) && (ret_tgl_r == ret_ack_r);
  dbs_fifo #(
    .W($bits(dbs_pkg::dbs_burst_t)),
    .DEPTH(`DBS_FIFO_DEPTH)
  ) u_fifo (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .in_valid_i(sy_pend_r),
    .in_ready_o(fifo_in_ready),
    .in_data_i(lk_hold_r),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(fifo_pop),
    .out_data_o(fifo_out)
  );

  // Core handshake decode and second-word address
  wire core_take = core_req_r && core_ready_i;
  wire ret_idle = (ret_tgl_r == ret_ack_r);
  wire [`DBS_ADDR_W-1:0] addr_second = {cur_r.addr[`DBS_ADDR_W-1:1], ~cur_r.addr[0]};
  assign core_req_o = core_req_r;
  assign core_we_o = core_we_r;
  assign core_addr_o = core_addr_r;
  assign core_wdata_o = core_wdata_r;
  assign core_ben_o = core_ben_r;

  // Core sequencer: two core accesses for every burst
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      state_r <= dbs_pkg::ST_IDLE;
      cur_r <= '0;
      core_req_r <= 1'b0;
      core_we_r <= 1'b0;
      core_addr_r <= '0;
      core_wdata_r <= '0;
      core_ben_r <= '0;
      ret_r <= '0;
      ret_tgl_r <= `DBS_TGL_RST;
    end else begin
      case (state_r)
        dbs_pkg::ST_IDLE: begin
          if (fifo_out_valid && fifo_pop) begin
            cur_r <= fifo_out;
            core_req_r <= 1'b1;
            core_we_r <= !fifo_out.rd;
            core_addr_r <= fifo_out.addr;
            core_wdata_r <= fifo_out.d0;
            core_ben_r <= fifo_out.rd ? '0 : ~fifo_out.bws0_n;
            state_r <= fifo_out.rd ? dbs_pkg::ST_RD0 : dbs_pkg::ST_WR0;
          end
        end
        dbs_pkg::ST_WR0: begin
          if (core_take) begin
            core_addr_r <= addr_second;
            core_wdata_r <= cur_r.d1;
            core_ben_r <= ~cur_r.bws1_n;
            state_r <= dbs_pkg::ST_WR1;
          end
        end
        dbs_pkg::ST_WR1: begin
          if (core_take) begin
            core_req_r <= 1'b0;
            core_we_r <= 1'b0;
            state_r <= dbs_pkg::ST_IDLE;
          end
        end
        dbs_pkg::ST_RD0: begin
          if (core_take) begin
            core_req_r <= 1'b0;
            state_r <= dbs_pkg::ST_RW0;
          end
        end
        dbs_pkg::ST_RW0: begin
          if (core_rvalid_i) begin
            ret_r.d0 <= core_rdata_i;
            core_req_r <= 1'b1;
            core_addr_r <= addr_second;
            state_r <= dbs_pkg::ST_RD1;
          end
        end
        dbs_pkg::ST_RD1: begin
          if (core_take) begin
            core_req_r <= 1'b0;
            state_r <= dbs_pkg::ST_RW1;
          end
        end
        dbs_pkg::ST_RW1: begin
          if (core_rvalid_i) begin
            ret_r.d1 <= core_rdata_i;
            state_r <= dbs_pkg::ST_RET;
          end
        end
        dbs_pkg::ST_RET: begin
          if (ret_idle) begin
            ret_tgl_r <= ~ret_tgl_r;
            state_r <= dbs_pkg::ST_IDLE;
          end
        end
        default: begin
          state_r <= dbs_pkg::ST_IDLE;
          core_req_r <= 1'b0;
        end
      endcase
    end
  end

  // Acknowledge of the read pair, back on clock_i
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      ret_ack_m_r <= `DBS_TGL_RST;
      ret_ack_r <= `DBS_TGL_RST;
    end else begin
      ret_ack_m_r <= rc_ack_tgl_r;
      ret_ack_r <= ret_ack_m_r;
    end
  end

  // Read-out clock: output pair, or input pair in single clock mode
  wire rd_clk = single_clock_i ? link_clk_i : out_clk_i;

  // Core reset brought onto the read-out clock
  always_ff @(posedge rd_clk) begin
    rc_rst_m_r <= rst_i;
    rc_rst_r <= rc_rst_m_r;
  end

  // Take the pair, then drive word one on the next rising edge
  wire rc_new = rc_req_r ^ rc_req_d_r;
  always_ff @(posedge rd_clk) begin
    if (rc_rst_r) begin
      rc_req_m_r <= `DBS_TGL_RST;
      rc_req_r <= `DBS_TGL_RST;
      rc_req_d_r <= `DBS_TGL_RST;
      rc_ack_tgl_r <= `DBS_TGL_RST;
      rc_pair_r <= '0;
      rc_arm_r <= 1'b0;
      rc_drive_r <= 1'b0;
      rc_pos_d_r <= '0;
      rc_pos_oe_n_r <= `DBS_OE_N_RST;
    end else begin
      rc_req_m_r <= ret_tgl_r;
      rc_req_r <= rc_req_m_r;
      rc_req_d_r <= rc_req_r;
      if (rc_new) begin
        rc_pair_r <= ret_r;
        rc_ack_tgl_r <= ~rc_ack_tgl_r;
      end
      rc_arm_r <= rc_new;
      rc_drive_r <= rc_arm_r;
      rc_pos_d_r <= rc_pair_r.d0;
      rc_pos_oe_n_r <= !rc_arm_r;
    end
  end

  // Word two on the complementary edge of the read-out clock
  always_ff @(negedge rd_clk) begin
    if (rc_rst_r) begin
      rc_neg_d_r <= '0;
      rc_neg_oe_n_r <= `DBS_OE_N_RST;
    end else begin
      rc_neg_d_r <= rc_pair_r.d1;
      rc_neg_oe_n_r <= !rc_drive_r;
    end
  end

  // Double-rate output: each half of the read clock shows its own flop
  assign dq_o = rd_clk ? rc_pos_d_r : rc_neg_d_r;
  assign dq_oe_n_o = rd_clk ? rc_pos_oe_n_r : rc_neg_oe_n_r;

endmodule : dbs_port

/* dv/dbs_checker.sv */
/*
  Port checker for the burst SRAM data port.
  Assumes it is bound to dbs_port and sees only that module's ports.
*/
`timescale 1ns/100ps
`include "dbs_cfg.svh"

module dbs_checker (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic link_clk_i,
  input wire logic out_clk_i,
  input wire logic single_clock_i,
  input wire logic dq_oe_n_o,
  input wire logic overrun_o,
  input wire logic core_req_o,
  input wire logic core_we_o,
  input wire logic [`DBS_ADDR_W-1:0] core_addr_o,
  input wire logic [`DBS_BYTE_N-1:0] core_ben_o,
  input wire logic core_ready_i
);
  logic word_r;
  logic [`DBS_ADDR_W-1:0] first_r;
  wire take = core_req_o && core_ready_i;
  wire rd_clk = single_clock_i ? link_clk_i : out_clk_i;

  // Which word of the burst the core side is on
  always_ff @(posedge clock_i) begin
    if (rst_i) word_r <= 1'h0;
    else if (take) word_r <= ~word_r;
  end

  // Address of the first word of the burst
  always_ff @(posedge clock_i) begin
    if (take && !word_r) first_r <= core_addr_o;
  end

  property p_rst_quiet;
    @(posedge clock_i) rst_i |=> !core_req_o && !overrun_o && core_ben_o == '0;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet)
    else $error("core side active in reset");

  property p_req_hold;
    @(posedge clock_i) disable iff (rst_i)
      core_req_o && !core_ready_i |=> core_req_o && $stable(core_addr_o) && $stable(core_we_o);
  endproperty
  a_req_hold: assert property (p_req_hold)
    else $error("core request changed before accept");

  property p_rd_ben;
    @(posedge clock_i) disable iff (rst_i) core_req_o && !core_we_o |-> core_ben_o == '0;
  endproperty
  a_rd_ben: assert property (p_rd_ben)
    else $error("byte enables set on a read");

  property p_second_addr;
    @(posedge clock_i) disable iff (rst_i)
      core_req_o && word_r |-> core_addr_o == {first_r[`DBS_ADDR_W-1:1], ~first_r[0]};
  endproperty
  a_second_addr: assert property (p_second_addr)
    else $error("second word address not stepped");

  property p_two_words;
    @(posedge clock_i) disable iff (rst_i) take && word_r |=> !core_req_o;
  endproperty
  a_two_words: assert property (p_two_words)
    else $error("burst longer than two words");

  property p_overrun_sticky;
    @(posedge clock_i) disable iff (rst_i) overrun_o |=> overrun_o;
  endproperty
  a_overrun_sticky: assert property (p_overrun_sticky)
    else $error("overrun flag cleared without reset");

  property p_oe_rst;
    @(posedge clock_i) rst_i && $past(rst_i, 6) |-> dq_oe_n_o;
  endproperty
  a_oe_rst: assert property (p_oe_rst)
    else $error("data pins driven in reset");

  property p_oe_pulse;
    @(posedge rd_clk) disable iff (rst_i) !dq_oe_n_o |=> dq_oe_n_o;
  endproperty
  a_oe_pulse: assert property (p_oe_pulse)
    else $error("data pins driven longer than one burst");
endmodule : dbs_checker

bind dbs_port dbs_checker u_chk (.clock_i(clock_i), .rst_i(rst_i), .link_clk_i(link_clk_i),
  .out_clk_i(out_clk_i), .single_clock_i(single_clock_i), .dq_oe_n_o(dq_oe_n_o),
  .overrun_o(overrun_o), .core_req_o(core_req_o), .core_we_o(core_we_o),
  .core_addr_o(core_addr_o), .core_ben_o(core_ben_o), .core_ready_i(core_ready_i));

/* dv/dbs_ctrl_model.sv */
/*
  Memory controller model: load, direction, address, write data and selects.
  Assumes the bench resolves the shared data pins and runs the link clock.
*/
`timescale 1ns/100ps
`include "dbs_cfg.svh"

module dbs_ctrl_model (
  input wire logic link_clk_i,
  output logic load_n_o,
  output logic read_write_n_o,
  output logic [`DBS_ADDR_W-2:0] addr_o,
  output logic burst_lsb_o,
  output logic [`DBS_DATA_W-1:0] dq_o,
  output logic [`DBS_BYTE_N-1:0] bws_n_o
);
  // Idle bus
  initial begin
    load_n_o = 1'h1;
    read_write_n_o = 1'h1;
    {addr_o, burst_lsb_o} = '0;
    dq_o = '0;
    bws_n_o = '1;
  end

  // Define a cycle at the next rising edge, then scramble the address
  task automatic load(input logic rd, input logic [`DBS_ADDR_W-1:0] a);
    @(posedge link_clk_i) #5;
    load_n_o = 1'h0;
    read_write_n_o = rd;
    {addr_o, burst_lsb_o} = a;
    @(posedge link_clk_i) #5;
    load_n_o = 1'h1;
    read_write_n_o = ~rd;
    addr_o = ~addr_o;
  endtask : load

  // Write burst: word one for the rise after load, word two for the fall
  task automatic wr(input logic [`DBS_ADDR_W-1:0] a, input logic [`DBS_DATA_W-1:0] d0, d1,
                    input logic [`DBS_BYTE_N-1:0] s0, s1);
    load(1'h0, a);
    dq_o = d0;
    bws_n_o = s0;
    @(posedge link_clk_i) #5;
    dq_o = d1;
    bws_n_o = s1;
    @(negedge link_clk_i) #5;
    dq_o = ~d1;
    bws_n_o = ~s1;
  endtask : wr

  // Read burst: load only, data pins left to the device
  task automatic rd(input logic [`DBS_ADDR_W-1:0] a);
    load(1'h1, a);
  endtask : rd
endmodule : dbs_ctrl_model

/* dv/testbench.sv */
/*
  Self-checking bench for dbs_port with a controller model and a core memory model.
  Assumes the package, the controller model and the checker are compiled first.
*/
`timescale 1ns/100ps
`include "dbs_cfg.svh"
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_errors++; \
  $display("BAD %0t got %h expected %h", $time, g, e); end end

module testbench;
  logic clock_i = 1'h0;
  logic rst_i = 1'h1;
  logic link_clk = 1'h0;
  logic out_clk = 1'h1;
  logic single_clock = 1'h0;
  logic load_n, rw_n, lsb, dq_oe_n, overrun, core_req, core_we, c_rd;
  logic core_ready = 1'h0;
  logic core_rvalid = 1'h0;
  logic [`DBS_ADDR_W-2:0] addr;
  logic [`DBS_ADDR_W-1:0] core_addr, c_a, a;
  logic [`DBS_DATA_W-1:0] ctl_dq, dut_dq, core_wdata, r36;
  logic [`DBS_DATA_W-1:0] core_rdata = '0;
  logic [`DBS_BYTE_N-1:0] bws_n, core_ben;
  logic [`DBS_DATA_W-1:0] mem [logic [`DBS_ADDR_W-1:0]];
  logic [`DBS_DATA_W-1:0] shadow [logic [`DBS_ADDR_W-1:0]];
  dbs_pkg::dbs_rdpair_t exp_q[$];
  dbs_pkg::dbs_rdpair_t exp_p;
  integer seed = 32'h677d;
  int n_errors = 0;
  int cmp_count = 0;
  wire [`DBS_DATA_W-1:0] dq_wire = !dq_oe_n ? dut_dq : ctl_dq;
  wire rd_clk = single_clock ? link_clk : out_clk;

  // Core clock, link clock and output clock
  always #50 clock_i = ~clock_i;
  always #80 link_clk = ~link_clk;
  always #80 out_clk = ~out_clk;

  dbs_ctrl_model ctl (.link_clk_i(link_clk), .load_n_o(load_n), .read_write_n_o(rw_n),
    .addr_o(addr), .burst_lsb_o(lsb), .dq_o(ctl_dq), .bws_n_o(bws_n));

  dbs_port DUT (.clock_i(clock_i), .rst_i(rst_i), .link_clk_i(link_clk), .out_clk_i(out_clk),
    .single_clock_i(single_clock), .load_n_i(load_n), .read_write_n_i(rw_n), .addr_i(addr),
    .burst_lsb_i(lsb), .dq_i(dq_wire), .byte_write_select_n_i(bws_n), .dq_o(dut_dq),
    .dq_oe_n_o(dq_oe_n), .overrun_o(overrun), .core_req_o(core_req), .core_we_o(core_we),
    .core_addr_o(core_addr), .core_wdata_o(core_wdata), .core_ben_o(core_ben),
    .core_ready_i(core_ready), .core_rdata_i(core_rdata), .core_rvalid_i(core_rvalid));

  // Keep only the selected bytes of a new word
  function automatic logic [`DBS_DATA_W-1:0] merge(input logic [`DBS_DATA_W-1:0] old, nw,
                                                   input logic [`DBS_BYTE_N-1:0] sel_n);
    merge = old;
    for (int b = 0; b < `DBS_BYTE_N; b++) if (!sel_n[b])
      merge[b*`DBS_BYTE_W +: `DBS_BYTE_W] = nw[b*`DBS_BYTE_W +: `DBS_BYTE_W];
  endfunction : merge

  function automatic logic [`DBS_DATA_W-1:0] rnd();
    logic [63:0] w;
    w = {$random(seed), $random(seed)};
    return w[`DBS_DATA_W-1:0];
  endfunction : rnd

  // Core memory model with a randomly stalling accept
  always @(posedge clock_i) begin
    if (core_req === 1'h1 && core_ready && core_we)
      mem[core_addr] = merge(mem.exists(core_addr) ? mem[core_addr] : '0, core_wdata, ~core_ben);
    c_rd = core_req === 1'h1 && core_ready && !core_we;
    c_a = core_addr;
    #5;
    r36 = rnd();
    core_ready = r36[0];
    core_rvalid = c_rd;
    core_rdata = c_rd ? mem[c_a] : r36;
  end

  // Write burst and its expected effect on memory
  task automatic do_wr(input logic [`DBS_ADDR_W-1:0] wa, input logic [`DBS_BYTE_N-1:0] s0, s1);
    logic [`DBS_DATA_W-1:0] d0, d1;
    logic [`DBS_ADDR_W-1:0] wb;
    d0 = rnd();
    d1 = rnd();
    wb = {wa[`DBS_ADDR_W-1:1], ~wa[0]};
    ctl.wr(wa, d0, d1, s0, s1);
    shadow[wa] = merge(shadow.exists(wa) ? shadow[wa] : '0, d0, s0);
    shadow[wb] = merge(shadow.exists(wb) ? shadow[wb] : '0, d1, s1);
    repeat (10) @(posedge link_clk);
  endtask : do_wr

  // Read burst: note the expected pair first, keep the pins free until it is back
  task automatic do_rd(input logic [`DBS_ADDR_W-1:0] ra);
    exp_q.push_back({shadow[ra], shadow[{ra[`DBS_ADDR_W-1:1], ~ra[0]}]});
    ctl.rd(ra);
    for (int k = 0; k < 60 && exp_q.size() != 0; k++) @(posedge link_clk);
    `CHK(exp_q.size(), 0)
    if (exp_q.size() != 0) results();
    repeat (4) @(posedge link_clk);
  endtask : do_rd

  // Read data watcher: word one in the high half, word two in the low half
  always @(posedge rd_clk) begin
    #20;
    if (dq_oe_n === 1'h0) begin
      if (exp_q.size() == 0) `CHK(dq_oe_n, 1'h1)
      else begin
        exp_p = exp_q.pop_front();
        `CHK(dut_dq, exp_p.d0)
        @(negedge rd_clk) #20;
        `CHK(dut_dq, exp_p.d1)
        `CHK(dq_oe_n, 1'h0)
      end
    end
  end

  task automatic results();
    $display("errors %0d comparisons %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : results

  // Main sequence
  initial begin
    repeat (8) @(posedge clock_i);
    #5 rst_i = 1'h0;
    repeat (4) @(posedge link_clk);
    for (int i = 0; i < 6; i++) begin
      r36 = rnd();
      a = (i == 0) ? '1 : r36[`DBS_ADDR_W-1:0];
      do_wr(a, 4'h0, 4'h0);
      do_wr(a, r36[35:32], r36[31:28]);
      do_rd(a);
    end
    `CHK(overrun, 1'h0)
    // Back-to-back loads with every byte deselected
    ctl.wr(a, r36, ~r36, 4'hf, 4'hf);
    ctl.wr(a, ~r36, r36, 4'hf, 4'hf);
    repeat (10) @(posedge link_clk);
    `CHK(overrun, 1'h1)
    do_rd(a);
    // Second reset, then single clock mode
    @(posedge clock_i) #5 rst_i = 1'h1;
    single_clock = 1'h1;
    repeat (8) @(posedge clock_i);
    #5 rst_i = 1'h0;
    repeat (4) @(posedge link_clk);
    `CHK(overrun, 1'h0)
    do_wr(a, 4'h0, 4'h5);
    do_rd(a);
    for (int k = 0; k < 300 && exp_q.size() != 0; k++) @(posedge clock_i);
    `CHK(exp_q.size(), 0)
    results();
  end
endmodule : testbench
